// ---- src/dgcs_hyst_count.sv ----
`timescale 1ns/1ps
module dgcs_hyst_count
    import dgcs_pkg::*;
#(
    parameter int THERMO_W = HYST_W,
    parameter int CNT_W    = HYST_CNT_W
)
(
    input  wire logic [THERMO_W-1:0] thermo,
    output logic      [CNT_W-1:0]    steps,
    output logic                     code_ok
);

    logic [THERMO_W-1:0] gap;

    // A set bit above a clear one breaks the thermometer form
    assign gap[0] = 1'b0;
    genvar g;
    generate
        for (g = 1; g < THERMO_W; g++)
        begin : g_gap
            assign gap[g] = thermo[g] & ~thermo[g-1];
        end
    endgenerate
    assign code_ok = ~|gap;

    // Each set bit is one equal hysteresis step
    always_comb
    begin
        steps = '0;
        for (int k = 0; k < THERMO_W; k++)
            steps = steps + CNT_W'(thermo[k]);
    end

endmodule

// ---- src/dgcs_pkg.sv ----
package dgcs_pkg;

    localparam int ADDR_W       = 15;
    localparam int DATA_W       = 8;
    localparam int GAIN_W       = 10;
    localparam int GAIN_HI_LSB  = 8;
    localparam int HYST_W       = 10;
    localparam int HYST_HI_LSB  = 8;
    localparam int HYST_CNT_W   = 4;
    localparam int SPI_INSTR_W  = 16;
    localparam int SPI_FRAME_W  = 24;
    localparam int SPI_CNT_W    = 5;

    localparam logic [ADDR_W-1:0] ADDR_I_GAIN_HIGH = 15'h0040;
    localparam logic [ADDR_W-1:0] ADDR_I_GAIN_LOW  = 15'h0041;
    localparam logic [ADDR_W-1:0] ADDR_Q_GAIN_HIGH = 15'h0044;
    localparam logic [ADDR_W-1:0] ADDR_Q_GAIN_LOW  = 15'h0045;
    localparam logic [ADDR_W-1:0] ADDR_CLOCK_CFG   = 15'h0080;
    localparam logic [ADDR_W-1:0] ADDR_SYNC_CTRL   = 15'h0081;
    localparam logic [ADDR_W-1:0] ADDR_HYST_LOW    = 15'h0082;

    localparam logic [DATA_W-1:0] RST_GAIN       = 8'h00;
    localparam logic [DATA_W-1:0] RST_CLOCK_CFG  = 8'hF8;
    localparam logic [DATA_W-1:0] RST_SYNC_CTRL  = 8'h10;
    localparam logic [DATA_W-1:0] RST_HYST_LOW   = 8'h00;
    localparam logic [DATA_W-1:0] MASK_GAIN_HIGH = 8'h03;
    localparam logic [DATA_W-1:0] MASK_CLOCK_CFG = 8'hF8;
    localparam logic [DATA_W-1:0] MASK_SYNC_CTRL = 8'h1F;

    localparam int BIT_CHAN0_OFF   = 7;
    localparam int BIT_CHAN1_OFF   = 6;
    localparam int BIT_ALL_OFF     = 5;
    localparam int BIT_REFCLK_OFF  = 4;
    localparam int BIT_RECEIVER_OFF = 3;
    localparam int BIT_SYNC_OFF    = 4;
    localparam int BIT_HYST_EN     = 3;
    localparam int BIT_EDGE_SEL    = 2;

    typedef struct packed {
        logic              strobe;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dgcs_req_type;

    typedef struct packed {
        logic                 csb_meta;
        logic                 csb_sync;
        logic                 sclk_meta;
        logic                 sclk_sync;
        logic                 sclk_prev;
        logic                 sdi_meta;
        logic                 sdi_sync;
        logic [SPI_CNT_W-1:0] bit_cnt;
        logic [SPI_INSTR_W-1:0] shift_in;
        logic [DATA_W-1:0]    shift_out;
        logic                 sdo;
        logic                 oe_n;
        dgcs_req_type         req;
    } dgcs_spi_state_type;

    typedef struct packed {
        logic [GAIN_W-1:0]     i_gain;
        logic [GAIN_W-1:0]     q_gain;
        logic [DATA_W-1:0]     clock_cfg;
        logic [DATA_W-1:0]     sync_ctrl;
        logic [DATA_W-1:0]     hyst_low;
        logic                  chan0_run;
        logic                  chan1_run;
        logic                  refclk_run;
        logic                  sync_rx_run;
        logic [HYST_CNT_W-1:0] hyst_steps;
        logic                  hyst_ok;
    } dgcs_regs_state_type;

endpackage

// ---- src/dgcs_regs.sv ----
`timescale 1ns/1ps
module dgcs_regs
    import dgcs_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic                     spi_sclk,
    input  wire logic                     spi_csb,
    input  wire logic                     spi_sdio_in,
    output logic                          spi_sdio_out,
    output logic                          spi_sdio_oe_n,
    output logic signed [GAIN_W-1:0]      i_full_scale_gain,
    output logic signed [GAIN_W-1:0]      q_full_scale_gain,
    output logic                          chan0_clock_off,
    output logic                          chan1_clock_off,
    output logic                          all_clocks_off,
    output logic                          link_pll_refclk_off,
    output logic                          clock_receiver_off,
    output logic                          chan0_clock_run,
    output logic                          chan1_clock_run,
    output logic                          link_pll_refclk_run,
    output logic                          sync_receiver_off,
    output logic                          sync_receiver_run,
    output logic                          hysteresis_enable,
    output logic                          sync_sample_edge_select,
    output logic [HYST_W-1:0]             hysteresis_amount,
    output logic [HYST_CNT_W-1:0]         hysteresis_steps,
    output logic                          hysteresis_code_ok
);

    dgcs_regs_state_type  st_reg;
    dgcs_regs_state_type  st_next;
    dgcs_req_type         req;
    logic [DATA_W-1:0]    rd_data;
    logic [HYST_W-1:0]    thermo;
    logic [HYST_CNT_W-1:0] raw_steps;
    logic                 raw_ok;
    logic                 clk_base_on;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    function automatic logic is_write(input dgcs_req_type r,
                                      input logic [ADDR_W-1:0] a);
        is_write = r.strobe && r.wr && (r.addr == a);
    endfunction

    function automatic logic [DATA_W-1:0] read_word(
        input logic [ADDR_W-1:0] a,
        input dgcs_regs_state_type s);
        logic [DATA_W-1:0] d;
        d = '0;
        case (a)
            ADDR_I_GAIN_HIGH:
                d = DATA_W'(s.i_gain[GAIN_W-1:GAIN_HI_LSB]);
            ADDR_I_GAIN_LOW:
                d = s.i_gain[GAIN_HI_LSB-1:0];
            ADDR_Q_GAIN_HIGH:
                d = DATA_W'(s.q_gain[GAIN_W-1:GAIN_HI_LSB]);
            ADDR_Q_GAIN_LOW:
                d = s.q_gain[GAIN_HI_LSB-1:0];
            ADDR_CLOCK_CFG:
                d = s.clock_cfg;
            ADDR_SYNC_CTRL:
                d = s.sync_ctrl;
            ADDR_HYST_LOW:
                d = s.hyst_low;
            default:
                d = '0;
        endcase
        read_word = d;
    endfunction

    dgcs_spi_slave u_spi
    (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .spi_sclk      (spi_sclk),
        .spi_csb       (spi_csb),
        .spi_sdio_in   (spi_sdio_in),
        .rd_data       (rd_data),
        .spi_sdio_out  (spi_sdio_out),
        .spi_sdio_oe_n (spi_sdio_oe_n),
        .req           (req)
    );

    // Unmapped and reserved positions read as zero
    assign rd_data = read_word(req.addr, st_reg);

    assign thermo = {st_reg.sync_ctrl[HYST_W-HYST_HI_LSB-1:0],
                     st_reg.hyst_low};

    dgcs_hyst_count u_hyst
    (
        .thermo  (thermo),
        .steps   (raw_steps),
        .code_ok (raw_ok)
    );

    always_comb
    begin
        st_next = st_reg;
        if (is_write(req, ADDR_I_GAIN_HIGH))
            st_next.i_gain[GAIN_W-1:GAIN_HI_LSB] =
                req.wdata[GAIN_W-GAIN_HI_LSB-1:0];
        if (is_write(req, ADDR_I_GAIN_LOW))
            st_next.i_gain[GAIN_HI_LSB-1:0] = req.wdata;
        if (is_write(req, ADDR_Q_GAIN_HIGH))
            st_next.q_gain[GAIN_W-1:GAIN_HI_LSB] =
                req.wdata[GAIN_W-GAIN_HI_LSB-1:0];
        if (is_write(req, ADDR_Q_GAIN_LOW))
            st_next.q_gain[GAIN_HI_LSB-1:0] = req.wdata;
        if (is_write(req, ADDR_CLOCK_CFG))
            st_next.clock_cfg = req.wdata & MASK_CLOCK_CFG;
        if (is_write(req, ADDR_SYNC_CTRL))
            st_next.sync_ctrl = req.wdata & MASK_SYNC_CTRL;
        if (is_write(req, ADDR_HYST_LOW))
            st_next.hyst_low = req.wdata;

        // The receiver and the global gate override the channel gates
        clk_base_on = ~st_next.clock_cfg[BIT_RECEIVER_OFF]
                    & ~st_next.clock_cfg[BIT_ALL_OFF];
        st_next.chan0_run = clk_base_on
                          & ~st_next.clock_cfg[BIT_CHAN0_OFF];
        st_next.chan1_run = clk_base_on
                          & ~st_next.clock_cfg[BIT_CHAN1_OFF];
        st_next.refclk_run = clk_base_on
                           & ~st_next.clock_cfg[BIT_REFCLK_OFF];
        st_next.sync_rx_run = ~st_next.sync_ctrl[BIT_SYNC_OFF];

        // Hysteresis counts only with the receiver up and enabled
        if (st_reg.sync_ctrl[BIT_HYST_EN]
            && !st_reg.sync_ctrl[BIT_SYNC_OFF])
            st_next.hyst_steps = raw_steps;
        else
            st_next.hyst_steps = '0;
        st_next.hyst_ok = raw_ok;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_reg <= '0;
            st_reg.i_gain <= {GAIN_W{1'b0}};
            st_reg.q_gain <= {GAIN_W{1'b0}};
            st_reg.clock_cfg <= RST_CLOCK_CFG;
            st_reg.sync_ctrl <= RST_SYNC_CTRL;
            st_reg.hyst_low <= RST_HYST_LOW;
            st_reg.hyst_ok <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    // Gain words pass through as signed full-scale trims
    assign i_full_scale_gain = st_reg.i_gain;
    assign q_full_scale_gain = st_reg.q_gain;
    assign chan0_clock_off = st_reg.clock_cfg[BIT_CHAN0_OFF];
    assign chan1_clock_off = st_reg.clock_cfg[BIT_CHAN1_OFF];
    assign all_clocks_off = st_reg.clock_cfg[BIT_ALL_OFF];
    assign link_pll_refclk_off = st_reg.clock_cfg[BIT_REFCLK_OFF];
    assign clock_receiver_off = st_reg.clock_cfg[BIT_RECEIVER_OFF];
    assign chan0_clock_run = st_reg.chan0_run;
    assign chan1_clock_run = st_reg.chan1_run;
    assign link_pll_refclk_run = st_reg.refclk_run;
    assign sync_receiver_off = st_reg.sync_ctrl[BIT_SYNC_OFF];
    assign sync_receiver_run = st_reg.sync_rx_run;
    assign hysteresis_enable = st_reg.sync_ctrl[BIT_HYST_EN];
    // Zero samples on the rising converter clock edge
    assign sync_sample_edge_select =
        st_reg.sync_ctrl[BIT_EDGE_SEL];
    assign hysteresis_amount = thermo;
    assign hysteresis_steps = st_reg.hyst_steps;
    assign hysteresis_code_ok = st_reg.hyst_ok;

    AST_I_GAIN_HIGH:
    assert property (is_write(req, ADDR_I_GAIN_HIGH) |=>
        i_full_scale_gain[GAIN_W-1:GAIN_HI_LSB]
            == $past(req.wdata[1:0])
        && i_full_scale_gain[GAIN_HI_LSB-1:0]
            == $past(i_full_scale_gain[GAIN_HI_LSB-1:0]))
    else $error("I gain high write not stored");

    AST_I_GAIN_LOW:
    assert property (is_write(req, ADDR_I_GAIN_LOW) |=>
        i_full_scale_gain[GAIN_HI_LSB-1:0] == $past(req.wdata))
    else $error("I gain low write not stored");

    AST_Q_GAIN_HIGH:
    assert property (is_write(req, ADDR_Q_GAIN_HIGH) |=>
        q_full_scale_gain[GAIN_W-1:GAIN_HI_LSB]
            == $past(req.wdata[1:0])
        && q_full_scale_gain[GAIN_HI_LSB-1:0]
            == $past(q_full_scale_gain[GAIN_HI_LSB-1:0]))
    else $error("Q gain high write not stored");

    AST_Q_GAIN_LOW:
    assert property (is_write(req, ADDR_Q_GAIN_LOW) |=>
        q_full_scale_gain[GAIN_HI_LSB-1:0] == $past(req.wdata))
    else $error("Q gain low write not stored");

    AST_GAIN_HOLD:
    assert property (!req.strobe |=>
        $stable(i_full_scale_gain) && $stable(q_full_scale_gain))
    else $error("Gain changed without a write");

    AST_CHAN0_OFF:
    assert property (chan0_clock_off |-> !chan0_clock_run)
    else $error("Channel 0 clock runs while gated off");

    AST_CHAN1_OFF:
    assert property (chan1_clock_off |-> !chan1_clock_run)
    else $error("Channel 1 clock runs while gated off");

    AST_CHAN_RUN:
    assert property (chan0_clock_run
            == !(chan0_clock_off || all_clocks_off || clock_receiver_off)
        && chan1_clock_run
            == !(chan1_clock_off || all_clocks_off || clock_receiver_off))
    else $error("Channel clock gate wrong");

    AST_CLOCK_BITS:
    assert property (is_write(req, ADDR_CLOCK_CFG) |=>
        {chan0_clock_off, chan1_clock_off, all_clocks_off,
         link_pll_refclk_off, clock_receiver_off}
            == $past(req.wdata[BIT_CHAN0_OFF:BIT_RECEIVER_OFF]))
    else $error("Clock config write not stored");

    AST_ALL_OFF:
    assert property (all_clocks_off |->
        !chan0_clock_run && !chan1_clock_run && !link_pll_refclk_run)
    else $error("A clock runs while all clocks are off");

    AST_REFCLK:
    assert property (link_pll_refclk_run ==
        !(link_pll_refclk_off || all_clocks_off || clock_receiver_off))
    else $error("Link PLL reference gate wrong");

    AST_RECEIVER:
    assert property (clock_receiver_off |->
        !chan0_clock_run && !chan1_clock_run && !link_pll_refclk_run)
    else $error("A clock runs with the receiver down");

    AST_SYNC_OFF:
    assert property (sync_receiver_off |->
        !sync_receiver_run ##1 hysteresis_steps == '0)
    else $error("Sync receiver down but still active");

    AST_SYNC_BITS:
    assert property (is_write(req, ADDR_SYNC_CTRL) |=>
        sync_receiver_off == $past(req.wdata[BIT_SYNC_OFF])
        && hysteresis_enable == $past(req.wdata[BIT_HYST_EN]))
    else $error("Sync control flags not stored");

    AST_SYNC_RUN:
    assert property (sync_receiver_run == !sync_receiver_off)
    else $error("Sync receiver run flag wrong");

    AST_HYST_OFF:
    assert property (!hysteresis_enable |=> hysteresis_steps == '0)
    else $error("Hysteresis applied while disabled");

    AST_HYST_ON:
    assert property (hysteresis_enable && !sync_receiver_off |=>
        hysteresis_steps == HYST_CNT_W'($countones(
            $past(hysteresis_amount))))
    else $error("Applied hysteresis steps wrong");

    AST_HYST_UPPER:
    assert property (is_write(req, ADDR_SYNC_CTRL) |=>
        hysteresis_amount[HYST_W-1:HYST_HI_LSB] == $past(req.wdata[1:0])
        && sync_sample_edge_select == $past(req.wdata[BIT_EDGE_SEL]))
    else $error("Sync control write not stored");

    AST_HYST_LOWER:
    assert property (is_write(req, ADDR_HYST_LOW) |=>
        hysteresis_amount[HYST_HI_LSB-1:0] == $past(req.wdata))
    else $error("Hysteresis low write not stored");

    AST_CODE_OK:
    assert property (hysteresis_code_ok
        == ((($past(hysteresis_amount) + 1'b1)
             & $past(hysteresis_amount)) == '0))
    else $error("Thermometer check wrong");

    AST_GAIN_RESERVED:
    assert property (req.addr == ADDR_I_GAIN_HIGH
        || req.addr == ADDR_Q_GAIN_HIGH |->
        (rd_data & ~MASK_GAIN_HIGH) == '0)
    else $error("Reserved gain high bits read nonzero");

    AST_SYNC_RESERVED:
    assert property (req.addr == ADDR_SYNC_CTRL |->
        (rd_data & ~MASK_SYNC_CTRL) == '0)
    else $error("Reserved sync control bits read nonzero");

    AST_RESERVED:
    assert property (req.addr == ADDR_CLOCK_CFG |->
        (rd_data & ~MASK_CLOCK_CFG) == '0)
    else $error("Reserved clock config bits read nonzero");

endmodule

// ---- src/dgcs_spi_slave.sv ----
`timescale 1ns/1ps
module dgcs_spi_slave
    import dgcs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              spi_sclk,
    input  wire logic              spi_csb,
    input  wire logic              spi_sdio_in,
    input  wire logic [DATA_W-1:0] rd_data,
    output logic                   spi_sdio_out,
    output logic                   spi_sdio_oe_n,
    output dgcs_req_type           req
);

    dgcs_spi_state_type s_reg;
    dgcs_spi_state_type s_next;
    logic               rise;
    logic               fall;

    assign rise = s_reg.sclk_sync & ~s_reg.sclk_prev;
    assign fall = ~s_reg.sclk_sync & s_reg.sclk_prev;

    always_comb
    begin
        s_next = s_reg;
        s_next.csb_meta = spi_csb;
        s_next.csb_sync = s_reg.csb_meta;
        s_next.sclk_meta = spi_sclk;
        s_next.sclk_sync = s_reg.sclk_meta;
        s_next.sclk_prev = s_reg.sclk_sync;
        s_next.sdi_meta = spi_sdio_in;
        s_next.sdi_sync = s_reg.sdi_meta;
        s_next.req.strobe = 1'b0;
        if (s_reg.csb_sync)
        begin
            s_next.bit_cnt = '0;
            s_next.oe_n = 1'b1;
        end
        else
        begin
            // Bits are taken on the rising edge, MSB first
            if (rise && s_reg.bit_cnt != SPI_CNT_W'(SPI_FRAME_W))
            begin
                s_next.shift_in = {s_reg.shift_in[SPI_INSTR_W-2:0],
                                   s_reg.sdi_sync};
                s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
                if (s_reg.bit_cnt == SPI_CNT_W'(SPI_INSTR_W - 1))
                begin
                    s_next.req.wr = ~s_reg.shift_in[SPI_INSTR_W-2];
                    s_next.req.addr = {s_reg.shift_in[ADDR_W-2:0],
                                       s_reg.sdi_sync};
                end
                if (s_reg.bit_cnt == SPI_CNT_W'(SPI_FRAME_W - 1))
                begin
                    s_next.req.wdata = {s_reg.shift_in[DATA_W-2:0],
                                        s_reg.sdi_sync};
                    s_next.req.strobe = s_reg.req.wr;
                end
            end
            // Read data leaves on the falling edge
            if (fall && !s_reg.req.wr)
            begin
                if (s_reg.bit_cnt == SPI_CNT_W'(SPI_INSTR_W))
                begin
                    {s_next.sdo, s_next.shift_out} = {rd_data, 1'b0};
                    s_next.oe_n = 1'b0;
                end
                else if (s_reg.bit_cnt == SPI_CNT_W'(SPI_FRAME_W))
                    s_next.oe_n = 1'b1;
                else if (s_reg.bit_cnt > SPI_CNT_W'(SPI_INSTR_W))
                    {s_next.sdo, s_next.shift_out} =
                        {s_reg.shift_out, 1'b0};
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_reg <= '0;
            s_reg.csb_meta <= 1'b1;
            s_reg.csb_sync <= 1'b1;
            s_reg.oe_n <= 1'b1;
        end
        else
            s_reg <= s_next;
    end

    assign spi_sdio_out = s_reg.sdo;
    assign spi_sdio_oe_n = s_reg.oe_n;
    assign req = s_reg.req;

endmodule

// ---- verification/dgcs_regs_bench.sv ----
`timescale 1ns/1ps
module dgcs_regs_bench
    import dgcs_pkg::*;
;
    logic                     clk;
    logic                     sys_rst;
    logic                     spi_sclk;
    logic                     spi_csb;
    logic                     spi_sdio_in;
    logic                     spi_sdio_out;
    logic                     spi_sdio_oe_n;
    logic signed [GAIN_W-1:0] i_full_scale_gain;
    logic signed [GAIN_W-1:0] q_full_scale_gain;
    logic                     chan0_clock_off;
    logic                     chan1_clock_off;
    logic                     all_clocks_off;
    logic                     link_pll_refclk_off;
    logic                     clock_receiver_off;
    logic                     chan0_clock_run;
    logic                     chan1_clock_run;
    logic                     link_pll_refclk_run;
    logic                     sync_receiver_off;
    logic                     sync_receiver_run;
    logic                     hysteresis_enable;
    logic                     sync_sample_edge_select;
    logic [HYST_W-1:0]        hysteresis_amount;
    logic [HYST_CNT_W-1:0]    hysteresis_steps;
    logic                     hysteresis_code_ok;
    logic [7:0]               exp_q[$];
    logic [7:0]               rd_sh;
    int                       rd_n;
    int                       bad_count;
    int                       num_checks;
    logic [31:0]              seed;

    dgcs_regs i_dgcs_regs (
        .clk                     (clk),
        .sys_rst                 (sys_rst),
        .spi_sclk                (spi_sclk),
        .spi_csb                 (spi_csb),
        .spi_sdio_in             (spi_sdio_in),
        .spi_sdio_out            (spi_sdio_out),
        .spi_sdio_oe_n           (spi_sdio_oe_n),
        .i_full_scale_gain       (i_full_scale_gain),
        .q_full_scale_gain       (q_full_scale_gain),
        .chan0_clock_off         (chan0_clock_off),
        .chan1_clock_off         (chan1_clock_off),
        .all_clocks_off          (all_clocks_off),
        .link_pll_refclk_off     (link_pll_refclk_off),
        .clock_receiver_off      (clock_receiver_off),
        .chan0_clock_run         (chan0_clock_run),
        .chan1_clock_run         (chan1_clock_run),
        .link_pll_refclk_run     (link_pll_refclk_run),
        .sync_receiver_off       (sync_receiver_off),
        .sync_receiver_run       (sync_receiver_run),
        .hysteresis_enable       (hysteresis_enable),
        .sync_sample_edge_select (sync_sample_edge_select),
        .hysteresis_amount       (hysteresis_amount),
        .hysteresis_steps        (hysteresis_steps),
        .hysteresis_code_ok      (hysteresis_code_ok)
    );

    initial clk = 1'b0;
    always #2 clk = ~clk;

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t port got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_read(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t read got %h exp %h", $time, got, exp);
        end
    endtask

    // Sclk high and low 5 clk each; data line flips at the last sclk fall, before csb is released
    task automatic frame(input logic [23:0] f, input int nbits);
        spi_csb = 1'b0;
        tick(4);
        for (int k = 0; k < nbits; k++)
        begin
            spi_sclk = 1'b0;
            spi_sdio_in = f[23-k];
            tick(5);
            spi_sclk = 1'b1;
            tick(5);
        end
        spi_sclk = 1'b0;
        spi_sdio_in = ~spi_sdio_in;
        tick(5);
        spi_csb = 1'b1;
        tick(4);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        frame({1'b0, a, d}, 24);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        frame({1'b1, a, 8'h00}, 24);
    endtask

    // Read data is taken at each rising sclk while the pin is driven
    always @(posedge spi_sclk)
    begin
        if (spi_sdio_oe_n === 1'b0)
        begin
            rd_sh = {rd_sh[6:0], spi_sdio_out};
            rd_n++;
            if (rd_n == 8)
            begin
                rd_n = 0;
                if (exp_q.size() == 0)
                    chk_read(rd_sh, 8'hXX);
                else
                    chk_read(rd_sh, exp_q.pop_front());
            end
        end
    end

    task automatic check_clock(input logic [7:0] c);
        logic any;
        any = c[5] | c[3];
        chk(chan0_clock_off, c[7]);
        chk(chan0_clock_run, !(c[7] | any));
        chk(chan1_clock_off, c[6]);
        chk(chan1_clock_run, !(c[6] | any));
        chk(all_clocks_off, c[5]);
        chk(link_pll_refclk_off, c[4]);
        chk(link_pll_refclk_run, !(c[4] | any));
        chk(clock_receiver_off, c[3]);
    endtask

    task automatic check_sync(input logic [7:0] s, input logic [7:0] lo);
        logic [9:0] amt;
        int         n;
        amt = {s[1:0], lo};
        n = $countones(amt);
        chk(sync_receiver_off, s[4]);
        chk(sync_receiver_run, !s[4]);
        chk(hysteresis_enable, s[3]);
        chk(hysteresis_steps, (s[3] && !s[4]) ? n : 0);
        chk(sync_sample_edge_select, s[2]);
        chk(hysteresis_amount, amt);
        chk(hysteresis_code_ok, {1'b0, amt} == (11'h1 << n) - 11'h1);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (90000) @(posedge clk);
        bad_count++;
        $display("BAD t=%0t watchdog expired", $time);
        end_of_test();
    end

    initial
    begin
        logic [9:0] g;
        logic [7:0] c;
        logic [7:0] s;
        logic [7:0] lo;
        seed = 32'h1566;
        rd_n = 0;
        bad_count = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        spi_sclk = 1'b0;
        spi_csb = 1'b1;
        spi_sdio_in = 1'b0;
        tick(4);
        sys_rst = 1'b0;
        tick(4);
        check_clock(8'hF8);
        check_sync(8'h10, 8'h00);
        rd(ADDR_CLOCK_CFG, 8'hF8);
        rd(ADDR_SYNC_CTRL, 8'h10);
        rd(ADDR_I_GAIN_LOW, 8'h00);
        for (int k = 0; k < 6; k++)
        begin
            g = (k == 0) ? 10'h1FF : (k == 1) ? 10'h200 : rnd();
            wr(ADDR_I_GAIN_HIGH, {rnd(), g[9:8]});
            wr(ADDR_I_GAIN_LOW, g[7:0]);
            wr(ADDR_Q_GAIN_HIGH, {rnd(), ~g[9:8]});
            wr(ADDR_Q_GAIN_LOW, ~g[7:0]);
            chk($unsigned(i_full_scale_gain), g);
            chk($unsigned(q_full_scale_gain), 10'(~g));
            chk(i_full_scale_gain < 0, g[9]);
            rd(ADDR_I_GAIN_HIGH, {6'h00, g[9:8]});
            rd(ADDR_Q_GAIN_HIGH, {6'h00, ~g[9:8]});
            rd(ADDR_Q_GAIN_LOW, ~g[7:0]);
        end
        frame({1'b0, ADDR_I_GAIN_LOW, ~g[7:0]}, 20);
        rd(ADDR_I_GAIN_LOW, g[7:0]);
        for (int k = 0; k < 9; k++)
        begin
            c = (k < 5) ? 8'h80 >> k : (k == 5) ? 8'h00 : rnd();
            c = c & 8'hF8;
            wr(ADDR_CLOCK_CFG, c | {5'h00, 3'(rnd())});
            check_clock(c);
            rd(ADDR_CLOCK_CFG, c);
        end
        for (int k = 0; k < 10; k++)
        begin
            s = (k == 0) ? 8'h0B : (k == 1) ? 8'h1C : rnd();
            lo = k[0] ? rnd() : 8'hFF >> (rnd() % 9);
            wr(ADDR_SYNC_CTRL, s | {rnd(), 5'h00});
            wr(ADDR_HYST_LOW, lo);
            s = s & 8'h1F;
            check_sync(s, lo);
            rd(ADDR_SYNC_CTRL, s);
            rd(ADDR_HYST_LOW, lo);
        end
        wr(15'h0042, rnd());
        rd(15'h0042, 8'h00);
        rd(15'h0083, 8'h00);
        sys_rst = 1'b1;
        tick(2);
        sys_rst = 1'b0;
        tick(4);
        check_clock(8'hF8);
        check_sync(8'h10, 8'h00);
        chk(i_full_scale_gain, 10'h000);
        chk(q_full_scale_gain, 10'h000);
        chk(spi_sdio_oe_n, 1'b1);
        chk(spi_sdio_out, 1'b0);
        tick(10);
        if (exp_q.size() != 0)
            chk_read(8'hXX, 8'h00);
        end_of_test();
    end
endmodule
